// *** design/brcs_top.sv ***
// receive-side counters, pattern checker and status of the bit error tester
// assumes an ahb-lite master of single word transfers and a slow serial input
// pair (clock and data) well below half of hclk
//
// What this block does
// - count every received bit in 32 bits
// - counters keep running while out of lock
// - latch bit rising edge snapshots both counters
// - bit counter saturates and sets overflow flag
// - count mismatched bits in 24 bits, saturating
// - lock after 32 consecutive matching bits
// - six errors in 64 bits drop lock
// - error overflow flag latches, clears on read
// - bit overflow flag latches, clears on read
// - bit error flag only while locked, read-clear
// - loss-of-lock flag latches until read
// - all-zeros flag after 31 zeros, sticky
// - all-ones flag after 31 ones, sticky
// - error count low byte in status bits 8-15
// - error count upper sixteen bits at 051Ch
// - bit count split over two 16-bit registers
// - counter and status registers reset to zero
// - enabled error and lock-change events raise interrupt
`timescale 1ns/1ns
module brcs_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial receive pins
	input wire logic rx_clk_in,
	input wire logic rx_data_in,
	// interrupt
	output logic irq
);
	function automatic logic [31:0] sat_inc(input logic [31:0] val, input logic [31:0] max);
		sat_inc = (val == max) ? val : val + 32'h0000_0001;
	endfunction : sat_inc

	// pin synchronisers; first stages feed only the second
	logic clk_s1, clk_s2, clk_s3;
	logic dat_s1, dat_s2;
	logic bit_stb;
	logic rx_bit;

	// checker state
	brcs_pkg::brcs_state_t state;
	logic [brcs_pkg::hist_w-1:0] hist;
	logic [brcs_pkg::hist_w-1:0] gen;
	logic [5:0] match_cnt;
	logic [5:0] win_cnt;
	logic [2:0] win_err;
	logic exp_bit;
	logic mism;
	logic go_lock;
	logic go_search;

	// counters and snapshots
	logic [31:0] bit_cnt;
	logic [23:0] err_cnt;
	logic [31:0] snap_bc;
	logic [23:0] snap_ec;
	logic [4:0] zero_run;
	logic [4:0] one_run;

	// registers
	logic [15:0] ctrl;
	logic latch_q;
	brcs_pkg::brcs_flags_t flags;
	brcs_pkg::brcs_flags_t flag_set;
	brcs_pkg::brcs_flags_t flag_clr;
	logic lock_change;

	// bus
	logic acc_pend;
	logic acc_write;
	logic [11:0] acc_addr;
	logic [31:0] next_rdata;
	logic rd_status;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			dat_s1 <= 1'b0;
			dat_s2 <= 1'b0;
		end else begin
			clk_s1 <= rx_clk_in;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			dat_s1 <= rx_data_in;
			dat_s2 <= dat_s1;
		end
	end

	// data is taken on the rising edge of the receive clock
	assign bit_stb = clk_s2 & ~clk_s3;
	assign rx_bit = dat_s2;

	always_comb begin
		if (state == brcs_pkg::brcs_lock) begin
			exp_bit = gen[brcs_pkg::tap_a] ^ gen[brcs_pkg::tap_b];
		end else begin
			exp_bit = hist[brcs_pkg::tap_a] ^ hist[brcs_pkg::tap_b];
		end
	end

	assign mism = bit_stb & (rx_bit != exp_bit);
	assign go_lock = (state == brcs_pkg::brcs_search) & bit_stb & ~mism
		& (match_cnt == brcs_pkg::lock_need - 6'd1);
	assign go_search = (state == brcs_pkg::brcs_lock) & mism
		& (win_err == brcs_pkg::win_err_max - 3'd1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist <= '0;
			gen <= '0;
		end else if (bit_stb) begin
			hist <= {hist[brcs_pkg::hist_w-2:0], rx_bit};
			if (state == brcs_pkg::brcs_lock) begin
				gen <= {gen[brcs_pkg::hist_w-2:0], exp_bit};
			end else begin
				gen <= {hist[brcs_pkg::hist_w-2:0], rx_bit};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= brcs_pkg::brcs_search;
			match_cnt <= 6'd0;
			win_cnt <= 6'd0;
			win_err <= 3'd0;
		end else begin
			case (state)
				brcs_pkg::brcs_search: begin
					if (go_lock) begin
						state <= brcs_pkg::brcs_lock;
						match_cnt <= 6'd0;
						win_cnt <= 6'd0;
						win_err <= 3'd0;
					end else if (mism) begin
						match_cnt <= 6'd0;
					end else if (bit_stb) begin
						match_cnt <= match_cnt + 6'd1;
					end
				end
				brcs_pkg::brcs_lock: begin
					if (go_search) begin
						state <= brcs_pkg::brcs_search;
						win_cnt <= 6'd0;
						win_err <= 3'd0;
					end else if (bit_stb) begin
						// fixed 64-bit windows, not a sliding one
						win_cnt <= win_cnt + 6'd1;
						if (win_cnt == brcs_pkg::win_last) begin
							win_err <= 3'd0;
						end else if (mism) begin
							win_err <= win_err + 3'd1;
						end
					end
				end
				default: begin
					state <= brcs_pkg::brcs_search;
				end
			endcase
		end
	end

	// counters run in both checker states; clear bit holds them at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt <= brcs_pkg::zero32;
		end else if (ctrl[brcs_pkg::clear_pos]) begin
			bit_cnt <= brcs_pkg::zero32;
		end else if (bit_stb) begin
			bit_cnt <= sat_inc(bit_cnt, brcs_pkg::bc_max);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_cnt <= 24'h00_0000;
		end else if (ctrl[brcs_pkg::clear_pos]) begin
			err_cnt <= 24'h00_0000;
		end else if (mism) begin
			err_cnt <= 24'(sat_inc({8'h00, err_cnt}, brcs_pkg::ec_max));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			zero_run <= 5'd0;
			one_run <= 5'd0;
		end else if (bit_stb) begin
			if (rx_bit) begin
				zero_run <= 5'd0;
				one_run <= (one_run == brcs_pkg::run_need) ? one_run : one_run + 5'd1;
			end else begin
				one_run <= 5'd0;
				zero_run <= (zero_run == brcs_pkg::run_need) ? zero_run : zero_run + 5'd1;
			end
		end
	end

	// snapshot on the rising edge of the latch bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_q <= 1'b0;
			snap_bc <= brcs_pkg::zero32;
			snap_ec <= 24'h00_0000;
		end else begin
			latch_q <= ctrl[brcs_pkg::latch_pos];
			if (ctrl[brcs_pkg::latch_pos] & ~latch_q) begin
				snap_bc <= bit_cnt;
				snap_ec <= err_cnt;
			end
		end
	end

	// flag events and read-clear conditions
	always_comb begin
		flag_set.error_count_overflow = mism
			& (err_cnt == brcs_pkg::ec_max[23:0] - 24'h00_0001);
		flag_set.bit_count_overflow = bit_stb
			& (bit_cnt == brcs_pkg::bc_max - 32'h0000_0001);
		flag_set.bit_error_seen = mism & (state == brcs_pkg::brcs_lock);
		flag_set.lock_lost = go_search;
		flag_set.all_zeros_seen = bit_stb & ~rx_bit
			& (zero_run == brcs_pkg::run_need - 5'd1);
		flag_set.all_ones_seen = bit_stb & rx_bit
			& (one_run == brcs_pkg::run_need - 5'd1);
		flag_clr = rd_status ? 6'h3F : 6'h00;
		// a run still in progress keeps its flag through a read
		flag_clr.all_zeros_seen = rd_status & (zero_run != brcs_pkg::run_need);
		flag_clr.all_ones_seen = rd_status & (one_run != brcs_pkg::run_need);
	end

	// set wins over clear so an event in the read cycle is kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= brcs_pkg::flags_reset;
			lock_change <= 1'b0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
			lock_change <= (lock_change & ~rd_status) | go_lock | go_search;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= (ctrl[brcs_pkg::ien_err_pos] & flags.bit_error_seen)
				| (ctrl[brcs_pkg::ien_sync_pos] & lock_change);
		end
	end

	// bus: address phase is captured, one wait state, then data phase ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_pend <= 1'b0;
			acc_write <= 1'b0;
			acc_addr <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= okay_bit();
			if (hsel & htrans[1] & hready & ~acc_pend) begin
				acc_pend <= 1'b1;
				acc_write <= hwrite;
				acc_addr <= haddr[11:0];
				hreadyout <= 1'b0;
			end else begin
				acc_pend <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	function automatic logic okay_bit();
		okay_bit = brcs_pkg::okay_resp[0];
	endfunction : okay_bit

	assign rd_status = acc_pend & ~acc_write & (acc_addr == brcs_pkg::ec_lo_off);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= brcs_pkg::ctrl_reset;
		end else if (acc_pend & acc_write & (acc_addr == brcs_pkg::ctrl_off)) begin
			ctrl <= hwdata[15:0];
		end
	end

	always_comb begin
		next_rdata = brcs_pkg::zero32;
		case (acc_addr)
			brcs_pkg::ctrl_off: next_rdata = {16'h0000, ctrl};
			brcs_pkg::bc_lo_off: next_rdata = {16'h0000, snap_bc[15:0]};
			brcs_pkg::bc_hi_off: next_rdata = {16'h0000, snap_bc[31:16]};
			brcs_pkg::ec_lo_off: begin
				next_rdata[brcs_pkg::ec_byte_pos +: 8] = snap_ec[7:0];
				next_rdata[6:0] = {flags, state == brcs_pkg::brcs_lock};
			end
			brcs_pkg::ec_hi_off: next_rdata = {16'h0000, snap_ec[23:8]};
			default: next_rdata = brcs_pkg::zero32;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= brcs_pkg::zero32;
		end else if (acc_pend & ~acc_write) begin
			hrdata <= next_rdata;
		end
	end
endmodule : brcs_top

// *** include/brcs_pkg.sv ***
// constants, types and register map of the receive tester counters and status
// assumes a 32-bit ahb-lite slave with word accesses only
package brcs_pkg;
	// register byte offsets within the slave window
	localparam logic [11:0] ctrl_off = 12'h0500;
	localparam logic [11:0] bc_lo_off = 12'h0510;
	localparam logic [11:0] bc_hi_off = 12'h0514;
	localparam logic [11:0] ec_lo_off = 12'h0518;
	localparam logic [11:0] ec_hi_off = 12'h051C;
	// control field positions
	localparam int latch_pos = 0;
	localparam int clear_pos = 1;
	localparam int ien_err_pos = 14;
	localparam int ien_sync_pos = 15;
	localparam logic [15:0] ctrl_reset = 16'h0000;
	// status word: flags in bits 6..1, lock state in bit 0, error count byte from bit 8
	localparam int ec_byte_pos = 8;
	// checker figures
	localparam logic [5:0] lock_need = 6'd32;
	localparam logic [5:0] win_last = 6'd63;
	localparam logic [2:0] win_err_max = 3'd6;
	localparam logic [4:0] run_need = 5'd31;
	// self-synchronising prbs feedback taps of the expected pattern
	localparam int tap_a = 14;
	localparam int tap_b = 13;
	localparam int hist_w = 15;
	localparam logic [31:0] bc_max = 32'hFFFF_FFFF;
	localparam logic [31:0] ec_max = 32'h00FF_FFFF;
	localparam logic [31:0] zero32 = 32'h0000_0000;
	localparam logic [1:0] okay_resp = 2'h0;
	typedef enum logic [1:0] {
		brcs_search = 2'b00,
		brcs_lock = 2'b01
	} brcs_state_t;
	// latched flags, msb first, sitting in status bits 6..1
	typedef struct packed {
		logic all_ones_seen;
		logic all_zeros_seen;
		logic lock_lost;
		logic bit_error_seen;
		logic bit_count_overflow;
		logic error_count_overflow;
	} brcs_flags_t;
	localparam brcs_flags_t flags_reset = 6'h00;
endpackage : brcs_pkg

// *** dv/brcs_src.sv ***
// serial bit source standing in for the receive port of the tester
// assumes the bench calls send right after a rising hclk edge
`timescale 1ns/1ns
module brcs_src (
	// clock
	input wire logic hclk,
	// serial pins
	output logic rx_clk_in,
	output logic rx_data_in
);
	logic [14:0] hist;
	initial begin
		rx_clk_in = 1'b0;
		rx_data_in = 1'b0;
		hist = 15'h7FFF;
	end
	// mode 0 pattern, 1 zeros, 2 ones, 3 every bit errored
	task automatic send(input int n, input int mode);
		logic b;
		repeat (n) begin
			b = hist[brcs_pkg::tap_a] ^ hist[brcs_pkg::tap_b];
			// a flip leaves the history clean, as a locked checker predicts on its own
			hist = {hist[13:0], b};
			if (mode == 1 || mode == 2) begin
				b = (mode == 2);
				hist[0] = b;
			end else if (mode == 3) begin
				b = !b;
			end
			@(posedge hclk);
			rx_data_in <= b;
			repeat (3) @(posedge hclk);
			rx_clk_in <= 1'b1;
			repeat (4) @(posedge hclk);
			rx_clk_in <= 1'b0;
		end
		// released data line: no pull, so show the inverse
		rx_data_in <= !b;
		repeat (2) @(posedge hclk);
	endtask : send
endmodule : brcs_src

// *** dv/brcs_sva.sv ***
// checker for the tester counters and status block
// assumes hready tied to hreadyout and single word transfers
`timescale 1ns/1ns
module brcs_sva (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	// serial and interrupt
	input wire logic rx_clk_in,
	input wire logic irq
);
	logic rd_q, wr_q, rx_q, quiet, fresh, seen;
	logic [11:0] a_q;
	logic [3:0] since;
	logic [1:0] ie;
	logic [31:0] snap;
	wire rd = rd_q && hreadyout;
	wire wr = wr_q && hreadyout;
	wire rise = rx_clk_in && !rx_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			a_q <= 12'h0;
		end else if (hreadyout) begin
			rd_q <= hsel && htrans[1] && !hwrite;
			wr_q <= hsel && htrans[1] && hwrite;
			a_q <= haddr[11:0];
		end
	end
	// a bit lands a few hclk after its rise, so quiet needs a long gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_q <= 1'b0;
			since <= 4'h0;
			quiet <= 1'b0;
			fresh <= 1'b1;
		end else begin
			rx_q <= rx_clk_in;
			since <= rise ? 4'h0 : since + 4'(since != 4'hF);
			if (rise)
				quiet <= 1'b0;
			else if (rd && a_q == brcs_pkg::ec_lo_off)
				quiet <= since > 4'h7;
			if (rise || wr)
				fresh <= 1'b0;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ie <= 2'h0;
			seen <= 1'b0;
			snap <= 32'h0;
		end else begin
			if (wr && a_q == brcs_pkg::ctrl_off)
				ie <= hwdata[15:14];
			seen <= !wr && (seen || (rd && a_q == brcs_pkg::bc_lo_off));
			if (rd && a_q == brcs_pkg::bc_lo_off)
				snap <= hrdata;
		end
	end
	AST_RESET_IDLE: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !irq)
		else $error("outputs not idle after reset");
	AST_FIRST_READ_ZERO: assert property (rd && fresh |-> hrdata == 32'h0)
		else $error("register not zero after reset");
	AST_BIT_HALVES: assert property (rd && (a_q == brcs_pkg::bc_lo_off ||
		a_q == brcs_pkg::bc_hi_off) |-> hrdata[31:16] == 16'h0) else $error("bit count half wide");
	AST_ERR_HIGH: assert property (rd && a_q == brcs_pkg::ec_hi_off |-> hrdata[31:16] == 16'h0)
		else $error("error count high wide");
	AST_STATUS_WORD: assert property (rd && a_q == brcs_pkg::ec_lo_off |->
		hrdata[31:16] == 16'h0 && !hrdata[7]) else $error("status word bad");
	AST_READ_CLEARS: assert property (rd && a_q == brcs_pkg::ec_lo_off && quiet |->
		hrdata[4:1] == 4'h0) else $error("flag survived read");
	AST_SNAP_HOLDS: assert property (rd && a_q == brcs_pkg::bc_lo_off && seen |-> hrdata == snap)
		else $error("snapshot moved without latch");
	AST_IRQ_MASKED: assert property (irq && !wr |-> ie != 2'h0)
		else $error("interrupt while masked");
endmodule : brcs_sva
bind brcs_top brcs_sva sva_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .rx_clk_in(rx_clk_in), .irq(irq));

// *** dv/test_bert_receive_counters_status.sv ***
// self-checking bench for the tester counters and status block
// assumes the package, brcs_top, brcs_src and the checker compiled first
`timescale 1ns/1ns
module test_bert_receive_counters_status;
	localparam logic [31:0] all = 32'hFFFF_FFFF;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rx_clk_in, rx_data_in;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	int fail_count, samples_checked;
	brcs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_clk_in(rx_clk_in),
		.rx_data_in(rx_data_in), .irq(irq));
	brcs_src src_u (.hclk(hclk), .rx_clk_in(rx_clk_in), .rx_data_in(rx_data_in));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			stop_test();
		end
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : xfer
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, a, 32'h0);
		chk(q & m, e & m);
	endtask : rdc
	// both halves must come from one snapshot
	task automatic latch(input logic [31:0] c);
		xfer(1'b1, brcs_pkg::ctrl_off, c);
		xfer(1'b1, brcs_pkg::ctrl_off, c | 32'h1);
	endtask : latch
	task automatic t_reset();
		for (int i = 0; i < 9; i++) begin
			rdc(12'h500 + 12'(4 * i), 32'h0, all);
		end
		xfer(1'b1, brcs_pkg::ec_hi_off, all);
		rdc(brcs_pkg::ec_hi_off, 32'h0, all);
		chk({31'h0, hresp}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_count();
		src_u.send(60, 0);
		xfer(1'b1, brcs_pkg::ctrl_off, 32'h2);
		latch(32'h0);
		src_u.send(40, 0);
		latch(32'h0);
		rdc(brcs_pkg::bc_lo_off, 32'h28, all);
		rdc(brcs_pkg::bc_hi_off, 32'h0, all);
		rdc(brcs_pkg::ec_lo_off, 32'h1, all);
		src_u.send(5, 0);
		rdc(brcs_pkg::bc_lo_off, 32'h28, all);
		$display("test count done");
	endtask : t_count
	task automatic t_errors();
		src_u.send(5, 3);
		src_u.send(10, 0);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, brcs_pkg::ctrl_off, 32'h4000);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		latch(32'h4000);
		rdc(brcs_pkg::ec_lo_off, 32'h509, all);
		rdc(brcs_pkg::bc_lo_off, 32'h3C, all);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rdc(brcs_pkg::ec_lo_off, 32'h501, all);
		src_u.send(12, 3);
		src_u.send(48, 0);
		latch(32'h8000);
		chk({31'h0, irq}, 32'h1);
		rdc(brcs_pkg::ec_lo_off, 32'h1319, all);
		rdc(brcs_pkg::ec_hi_off, 32'h0, all);
		rdc(brcs_pkg::bc_lo_off, 32'h78, all);
		rdc(brcs_pkg::ec_lo_off, 32'h1301, all);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		$display("test errors done");
	endtask : t_errors
	task automatic t_runs();
		logic [31:0] m;
		for (int v = 0; v < 2; v++) begin
			m = 32'h20 << v;
			src_u.send(1, 2 - v);
			src_u.send(30, 1 + v);
			rdc(brcs_pkg::ec_lo_off, 32'h0, m);
			src_u.send(1, 1 + v);
			rdc(brcs_pkg::ec_lo_off, m, m);
			src_u.send(1, 2 - v);
			rdc(brcs_pkg::ec_lo_off, m, m);
			rdc(brcs_pkg::ec_lo_off, 32'h0, m);
		end
		$display("test runs done");
	endtask : t_runs
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		fail_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_count();
		t_errors();
		t_runs();
		stop_test();
	end
endmodule : test_bert_receive_counters_status
